// [logic/bus_fault_status_flags.sv]
// Bus fault status flags, fault address registers and AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module bus_fault_status_flags (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire bus_fault_pkg::fault_evt_t evt,
	input wire logic [7:0] cur_pri,
	output logic bus_fault_pending,
	output logic bus_fault_activate,
	output logic [31:0] stacked_ret_pc
);
	bus_fault_pkg::fault_flags_t flags_q;
	bus_fault_pkg::fault_flags_t flags_d;
	logic [31:0] bus_fault_address_reg_q;
	logic [31:0] mem_mgmt_fault_address_reg_q;
	logic [7:0] bf_pri_q;
	logic prefetch_err_q;
	logic dp_wr_q;
	logic dp_rd_q;
	logic [7:0] dp_addr_q;
	logic addr_take;
	logic wr_fsr;
	logic wr_bfpri;
	logic ifetch_set;
	logic [31:0] rd_word;
	logic pend_w;
	logic act_w;

	// Set wins over a simultaneous write-one clear
	function automatic logic w1c_next(input logic cur, input logic set, input logic clr);
		w1c_next = (cur & ~clr) | set;
	endfunction

	// Address phase capture
	assign addr_take = hsel & hready & htrans[1] & (hsize == bus_fault_pkg::HSIZE_WORD);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hready) begin
			dp_wr_q <= addr_take & hwrite;
			dp_rd_q <= addr_take & ~hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	assign wr_fsr = dp_wr_q & (dp_addr_q == bus_fault_pkg::OFS_FSR);
	assign wr_bfpri = dp_wr_q & (dp_addr_q == bus_fault_pkg::OFS_BFPRI);

	// Zero wait state, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Prefetch error remembered until the instruction issues or is flushed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prefetch_err_q <= 1'b0;
		end else if (evt.instr_issue | evt.prefetch_flush) begin
			prefetch_err_q <= 1'b0;
		end else if (evt.prefetch_err) begin
			prefetch_err_q <= 1'b1;
		end
	end

	assign ifetch_set = evt.instr_issue & prefetch_err_q;

	always_comb begin
		flags_d.imprecise_data_bus_err = w1c_next(flags_q.imprecise_data_bus_err,
			evt.imprecise_data_bus_err, wr_fsr & hwdata[bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR]);
		flags_d.precise_data_bus_err = w1c_next(flags_q.precise_data_bus_err,
			evt.precise_err, wr_fsr & hwdata[bus_fault_pkg::BIT_PRECISE]);
		flags_d.instr_fetch_bus_err = w1c_next(flags_q.instr_fetch_bus_err,
			ifetch_set, wr_fsr & hwdata[bus_fault_pkg::BIT_IFETCH]);
		flags_d.mem_mgmt_addr_valid = w1c_next(flags_q.mem_mgmt_addr_valid,
			evt.mm_fault, wr_fsr & hwdata[bus_fault_pkg::BIT_MMVALID]);
	end

	// Flags are independent, so a precise fault never disturbs the imprecise one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= '{default: bus_fault_pkg::RST_FLAG};
		end else begin
			flags_q <= flags_d;
		end
	end

	// Only a precise data error loads the bus fault address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_fault_address_reg_q <= bus_fault_pkg::RST_ADDR;
			stacked_ret_pc <= bus_fault_pkg::RST_ADDR;
		end else if (evt.precise_err) begin
			bus_fault_address_reg_q <= evt.precise_addr;
			stacked_ret_pc <= evt.precise_pc;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_mgmt_fault_address_reg_q <= bus_fault_pkg::RST_ADDR;
		end else if (evt.mm_fault) begin
			mem_mgmt_fault_address_reg_q <= evt.mm_addr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bf_pri_q <= bus_fault_pkg::RST_BFPRI;
		end else if (wr_bfpri) begin
			bf_pri_q <= hwdata[7:0];
		end
	end

	imprecise_pend_arb u_pend (
		.hclk(hclk),
		.hresetn(hresetn),
		.detect(evt.imprecise_data_bus_err),
		.cur_pri(cur_pri),
		.bf_pri(bf_pri_q),
		.pending_q(pend_w),
		.activate_q(act_w)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_fault_pending <= 1'b0;
			bus_fault_activate <= 1'b0;
		end else begin
			bus_fault_pending <= pend_w;
			bus_fault_activate <= act_w;
		end
	end

	// Read mux uses next state so a read right after a write sees it
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (haddr[7:0])
			bus_fault_pkg::OFS_FSR: begin
				rd_word[bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR] = flags_d.imprecise_data_bus_err;
				rd_word[bus_fault_pkg::BIT_PRECISE] = flags_d.precise_data_bus_err;
				rd_word[bus_fault_pkg::BIT_IFETCH] = flags_d.instr_fetch_bus_err;
				rd_word[bus_fault_pkg::BIT_MMVALID] = flags_d.mem_mgmt_addr_valid;
			end
			bus_fault_pkg::OFS_BFAR: rd_word = bus_fault_address_reg_q;
			bus_fault_pkg::OFS_MMFAR: rd_word = mem_mgmt_fault_address_reg_q;
			bus_fault_pkg::OFS_BFPRI: rd_word[7:0] = wr_bfpri ? hwdata[7:0] : bf_pri_q;
			bus_fault_pkg::OFS_STAT: rd_word[1:0] = {act_w, pend_w};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_take & ~hwrite) begin
			hrdata <= rd_word;
		end
	end

	// Checks
	property p_imprecise_data_bus_err_no_addr;
		@(posedge hclk) disable iff (!hresetn)
		(evt.imprecise_data_bus_err && !evt.precise_err) |=> $stable(bus_fault_address_reg_q);
	endproperty
	a_imprecise_data_bus_err_no_addr: assert property (p_imprecise_data_bus_err_no_addr) else $error("imprecise loaded address");

	property p_both_flags;
		@(posedge hclk) disable iff (!hresetn)
		(flags_q.imprecise_data_bus_err && evt.precise_err && !wr_fsr)
			|=> (flags_q.imprecise_data_bus_err && flags_q.precise_data_bus_err);
	endproperty
	a_both_flags: assert property (p_both_flags) else $error("flags not both set");

	property p_precise_set;
		@(posedge hclk) disable iff (!hresetn)
		evt.precise_err |=> flags_q.precise_data_bus_err;
	endproperty
	a_precise_set: assert property (p_precise_set) else $error("precise flag not set");

	property p_stacked_pc;
		@(posedge hclk) disable iff (!hresetn)
		evt.precise_err |=> (stacked_ret_pc == $past(evt.precise_pc));
	endproperty
	a_stacked_pc: assert property (p_stacked_pc) else $error("wrong stacked pc");

	property p_precise_addr;
		@(posedge hclk) disable iff (!hresetn)
		evt.precise_err |=> (bus_fault_address_reg_q == $past(evt.precise_addr));
	endproperty
	a_precise_addr: assert property (p_precise_addr) else $error("fault address not loaded");

	property p_ifetch_cause;
		@(posedge hclk) disable iff (!hresetn)
		$rose(flags_q.instr_fetch_bus_err) |-> $past(evt.instr_issue && prefetch_err_q);
	endproperty
	a_ifetch_cause: assert property (p_ifetch_cause) else $error("ifetch flag without issue");

	property p_ifetch_no_addr;
		@(posedge hclk) disable iff (!hresetn)
		(evt.prefetch_err && !evt.prefetch_flush && !evt.instr_issue && !evt.precise_err)
			##1 (evt.instr_issue && !evt.precise_err)
			|=> flags_q.instr_fetch_bus_err && $stable(bus_fault_address_reg_q);
	endproperty
	a_ifetch_no_addr: assert property (p_ifetch_no_addr) else $error("ifetch handling wrong");

	property p_mm_valid;
		@(posedge hclk) disable iff (!hresetn)
		evt.mm_fault |=> (flags_q.mem_mgmt_addr_valid
			&& mem_mgmt_fault_address_reg_q == $past(evt.mm_addr));
	endproperty
	a_mm_valid: assert property (p_mm_valid) else $error("mm address not valid");

	property p_clear_by_one;
		@(posedge hclk) disable iff (!hresetn)
		$fell(flags_q.imprecise_data_bus_err) |-> $past(wr_fsr && hwdata[bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR]);
	endproperty
	a_clear_by_one: assert property (p_clear_by_one) else $error("flag cleared without w1");

	property p_zero_keeps;
		@(posedge hclk) disable iff (!hresetn)
		(flags_q.precise_data_bus_err && !(wr_fsr && hwdata[bus_fault_pkg::BIT_PRECISE]))
			|=> flags_q.precise_data_bus_err;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost without clear");

	property p_clear_precise;
		@(posedge hclk) disable iff (!hresetn)
		$fell(flags_q.precise_data_bus_err)
			|-> $past(wr_fsr && hwdata[bus_fault_pkg::BIT_PRECISE]);
	endproperty
	a_clear_precise: assert property (p_clear_precise)
		else $error("precise flag cleared without w1");

	property p_clear_ifetch;
		@(posedge hclk) disable iff (!hresetn)
		$fell(flags_q.instr_fetch_bus_err)
			|-> $past(wr_fsr && hwdata[bus_fault_pkg::BIT_IFETCH]);
	endproperty
	a_clear_ifetch: assert property (p_clear_ifetch)
		else $error("fetch flag cleared without w1");

	property p_clear_mmvalid;
		@(posedge hclk) disable iff (!hresetn)
		$fell(flags_q.mem_mgmt_addr_valid)
			|-> $past(wr_fsr && hwdata[bus_fault_pkg::BIT_MMVALID]);
	endproperty
	a_clear_mmvalid: assert property (p_clear_mmvalid)
		else $error("valid flag cleared without w1");

	property p_keep_imprecise_data_bus_err;
		@(posedge hclk) disable iff (!hresetn)
		(flags_q.imprecise_data_bus_err && !(wr_fsr && hwdata[bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR]))
			|=> flags_q.imprecise_data_bus_err;
	endproperty
	a_keep_imprecise_data_bus_err: assert property (p_keep_imprecise_data_bus_err)
		else $error("imprecise flag lost without clear");

	property p_keep_ifetch;
		@(posedge hclk) disable iff (!hresetn)
		(flags_q.instr_fetch_bus_err && !(wr_fsr && hwdata[bus_fault_pkg::BIT_IFETCH]))
			|=> flags_q.instr_fetch_bus_err;
	endproperty
	a_keep_ifetch: assert property (p_keep_ifetch)
		else $error("fetch flag lost without clear");

	property p_keep_mmvalid;
		@(posedge hclk) disable iff (!hresetn)
		(flags_q.mem_mgmt_addr_valid && !(wr_fsr && hwdata[bus_fault_pkg::BIT_MMVALID]))
			|=> flags_q.mem_mgmt_addr_valid;
	endproperty
	a_keep_mmvalid: assert property (p_keep_mmvalid)
		else $error("valid flag lost without clear");

	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		(evt.imprecise_data_bus_err && wr_fsr && hwdata[bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR])
			|=> flags_q.imprecise_data_bus_err;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat a new imprecise error");

	property p_bus_okay;
		@(posedge hclk) disable iff (!hresetn)
		(dp_wr_q || dp_rd_q) |-> (hreadyout && !hresp);
	endproperty
	a_bus_okay: assert property (p_bus_okay)
		else $error("bus transfer not ready or okay");

	property p_rdata_hold;
		@(posedge hclk) disable iff (!hresetn)
		!(addr_take && !hwrite) |=> $stable(hrdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without read");

	c_precise: cover property (@(posedge hclk) disable iff (!hresetn)
		evt.precise_err ##1 flags_q.precise_data_bus_err);
	c_both: cover property (@(posedge hclk) disable iff (!hresetn)
		flags_q.imprecise_data_bus_err && flags_q.precise_data_bus_err);
	c_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		flags_q.instr_fetch_bus_err ##[1:30] !flags_q.instr_fetch_bus_err);
	c_unblocked: cover property (@(posedge hclk) disable iff (!hresetn)
		(evt.imprecise_data_bus_err && (cur_pri >= bf_pri_q)) ##2 bus_fault_activate);
endmodule // bus_fault_status_flags

// [logic/bus_fault_pkg.sv]
// Package: offsets, field positions, reset values and carrier types for bus fault flags
// Summary of operation
// - An imprecise data bus error never loads the bus fault address register.
// - An imprecise fault seen while the current priority is above bus fault priority waits pending until priority drops.
// - A precise fault arriving before the imprecise handler runs leaves both flags set together.
// - The precise data bus error flag sits at bit 9, resets to 0 and sets on a precise data bus error.
// - On a precise data bus error the stacked return address is that of the faulting instruction.
// - On a precise data bus error the faulting access address is loaded into the bus fault address register.
// - The instruction bus error flag sits at bit 8, resets to 0, and reads 1 once such an error occurred.
// - A prefetch bus error is only remembered until the faulting instruction issues, then sets bit 8 without an address load.
// - Bit 7 says the memory management fault address register holds a valid address and resets to 0.
// - Each flag clears only when software writes a 1 to its bit.
package bus_fault_pkg;
	// Byte offsets on the register bus
	localparam logic [7:0] OFS_FSR = 8'h00;
	localparam logic [7:0] OFS_BFAR = 8'h04;
	localparam logic [7:0] OFS_MMFAR = 8'h08;
	localparam logic [7:0] OFS_BFPRI = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	// Fault status bit positions
	localparam int BIT_IMPRECISE_DATA_BUS_ERR = 10;
	localparam int BIT_PRECISE = 9;
	localparam int BIT_IFETCH = 8;
	localparam int BIT_MMVALID = 7;
	// Reset values, then the bus transfer type and size codes
	localparam logic RST_FLAG = 1'b0;
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	localparam logic [7:0] RST_BFPRI = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic imprecise_data_bus_err;
		logic precise_err;
		logic [31:0] precise_addr;
		logic [31:0] precise_pc;
		logic prefetch_err;
		logic prefetch_flush;
		logic instr_issue;
		logic mm_fault;
		logic [31:0] mm_addr;
	} fault_evt_t;

	typedef struct packed {
		logic imprecise_data_bus_err;
		logic precise_data_bus_err;
		logic instr_fetch_bus_err;
		logic mem_mgmt_addr_valid;
	} fault_flags_t;
endpackage

// [logic/imprecise_pend_arb.sv]
// Holds an imprecise bus fault pending against execution priority
`timescale 1ns/1ps
module imprecise_pend_arb (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic detect,
	input wire logic [7:0] cur_pri,
	input wire logic [7:0] bf_pri,
	output logic pending_q,
	output logic activate_q
);
	logic blocked;
	logic want;

	// Lower number means higher priority
	assign blocked = cur_pri < bf_pri;
	assign want = pending_q | detect;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_q <= 1'b0;
			activate_q <= 1'b0;
		end else begin
			activate_q <= want & ~blocked;
			pending_q <= want & blocked;
		end
	end

	property p_pend_hold;
		@(posedge hclk) disable iff (!hresetn)
		(detect && blocked) |=> (pending_q && !activate_q);
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("blocked fault not pending");

	property p_pend_release;
		@(posedge hclk) disable iff (!hresetn)
		(pending_q && !blocked) |=> (activate_q && !pending_q) ##1 (!activate_q || $past(detect)) [*1];
	endproperty
	a_pend_release: assert property (p_pend_release) else $error("pending fault not released");

	c_pend_release: cover property (@(posedge hclk) disable iff (!hresetn)
		pending_q ##[1:20] activate_q);
endmodule // imprecise_pend_arb

// [tb/bus_fault_status_flags_tb.sv]
// Self-checking testbench for the bus fault status flags block
`timescale 1ns/1ps
module bus_fault_status_flags_tb;
	localparam logic [7:0] FSR = bus_fault_pkg::OFS_FSR;
	localparam logic [7:0] BFAR = bus_fault_pkg::OFS_BFAR;
	localparam logic [7:0] MMFAR = bus_fault_pkg::OFS_MMFAR;
	localparam logic [7:0] PRI = bus_fault_pkg::OFS_BFPRI;
	localparam logic [7:0] STAT = bus_fault_pkg::OFS_STAT;
	localparam logic [31:0] B10 = 32'h1 << bus_fault_pkg::BIT_IMPRECISE_DATA_BUS_ERR;
	localparam logic [31:0] B9 = 32'h1 << bus_fault_pkg::BIT_PRECISE;
	localparam logic [31:0] B8 = 32'h1 << bus_fault_pkg::BIT_IFETCH;
	localparam logic [31:0] B7 = 32'h1 << bus_fault_pkg::BIT_MMVALID;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = bus_fault_pkg::HSIZE_WORD;
	logic [7:0] cur_pri = 8'h00;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic bus_fault_pending;
	logic bus_fault_activate;
	logic [31:0] hrdata;
	logic [31:0] stacked_ret_pc;
	bus_fault_pkg::fault_evt_t evt = '0;
	bus_fault_pkg::fault_evt_t e;
	bus_fault_pkg::fault_evt_t f;
	int num_errors = 0;
	int checks = 0;
	int n;
	logic dph_rd = 1'b0;
	logic [31:0] exp_q[$];
	string nm_q[$];
	logic [31:0] a1;
	logic [31:0] a2;
	logic [31:0] pc;

	assign hready = hreadyout;
	always #5 hclk = ~hclk;

	bus_fault_status_flags dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .cur_pri(cur_pri),
		.bus_fault_pending(bus_fault_pending), .bus_fault_activate(bus_fault_activate),
		.stacked_ret_pc(stacked_ret_pc));

	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task chk(input string s, input logic [31:0] x, input logic [31:0] y);
		checks++;
		if (y !== x) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, y);
		end
	endtask

	task wait_rdy;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask

	// Address phase held until hready, then data phase held until hready
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= bus_fault_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task rd(input string s, input logic [7:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		nm_q.push_back(s);
		xfer(a, 1'b0, 32'h0);
	endtask

	task pulse(input bus_fault_pkg::fault_evt_t x);
		@(posedge hclk);
		evt <= x;
		@(posedge hclk);
		evt <= '0;
	endtask

	// Two events on consecutive cycles
	task pulse2(input bus_fault_pkg::fault_evt_t x, input bus_fault_pkg::fault_evt_t y);
		@(posedge hclk);
		evt <= x;
		@(posedge hclk);
		evt <= y;
		@(posedge hclk);
		evt <= '0;
	endtask

	// Bounded wait for the activate pulse, sampled after it settles
	task wait_act;
		for (n = 0; n < 8 && bus_fault_activate !== 1'b1; n++) begin
			@(posedge hclk);
			#1;
		end
	endtask

	// Read data compared at the end of each read data phase
	always @(posedge hclk) begin
		if (dph_rd && exp_q.size() > 0) begin
			chk(nm_q.pop_front(), exp_q.pop_front(), hrdata);
			chk("hresp", 32'h0, {31'h0, hresp});
		end
		dph_rd <= hsel & hready & htrans[1] & ~hwrite;
	end

	initial begin
		#200000;
		num_errors++;
		stop_test();
	end

	initial begin
		void'($urandom(32'hCD8B20C0));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd("fsr", FSR, 32'h0);
		rd("bfar", BFAR, 32'h0);
		rd("mmfar", MMFAR, 32'h0);
		rd("stat", STAT, 32'h0);
		rd("bfpri", PRI, {24'h0, bus_fault_pkg::RST_BFPRI});
		rd("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		a1 = $urandom;
		pc = $urandom;
		e = '0;
		e.precise_err = 1'b1;
		e.precise_addr = a1;
		e.precise_pc = pc;
		pulse(e);
		#1;
		chk("ret_pc", pc, stacked_ret_pc);
		rd("fsr", FSR, B9);
		rd("bfar", BFAR, a1);
		wr(FSR, 32'h0);
		rd("fsr", FSR, B9);
		wr(FSR, B9);
		rd("fsr", FSR, 32'h0);
		$display("test precise done");
		wr(PRI, 32'h40);
		rd("bfpri", PRI, 32'h40);
		hsize <= 3'h0;
		wr(PRI, 32'h55);
		hsize <= bus_fault_pkg::HSIZE_WORD;
		rd("bfpri", PRI, 32'h40);
		@(posedge hclk);
		cur_pri <= 8'h10;
		e = '0;
		e.imprecise_data_bus_err = 1'b1;
		pulse(e);
		rd("fsr", FSR, B10);
		rd("bfar", BFAR, a1);
		rd("stat", STAT, 32'h1);
		chk("pending", 32'h1, {31'h0, bus_fault_pending});
		a2 = $urandom;
		e = '0;
		e.precise_err = 1'b1;
		e.precise_addr = a2;
		pulse(e);
		rd("fsr", FSR, B10 | B9);
		rd("bfar", BFAR, a2);
		@(posedge hclk);
		cur_pri <= 8'hFF;
		wait_act();
		chk("activate", 32'h1, {31'h0, bus_fault_activate});
		chk("pending", 32'h0, {31'h0, bus_fault_pending});
		rd("stat", STAT, 32'h0);
		wr(FSR, B10 | B9);
		rd("fsr", FSR, 32'h0);
		e = '0;
		e.imprecise_data_bus_err = 1'b1;
		pulse(e);
		wait_act();
		chk("activate", 32'h1, {31'h0, bus_fault_activate});
		chk("pending", 32'h0, {31'h0, bus_fault_pending});
		wr(FSR, B10);
		$display("test imprecise done");
		e = '0;
		e.prefetch_err = 1'b1;
		pulse(e);
		rd("fsr", FSR, 32'h0);
		e = '0;
		e.instr_issue = 1'b1;
		pulse(e);
		rd("fsr", FSR, B8);
		rd("bfar", BFAR, a2);
		wr(FSR, B8);
		e = '0;
		e.prefetch_err = 1'b1;
		pulse(e);
		e = '0;
		e.prefetch_flush = 1'b1;
		pulse(e);
		e = '0;
		e.instr_issue = 1'b1;
		pulse(e);
		rd("fsr", FSR, 32'h0);
		e = '0;
		e.prefetch_err = 1'b1;
		f = '0;
		f.instr_issue = 1'b1;
		pulse2(e, f);
		rd("fsr", FSR, B8);
		wr(FSR, B8);
		$display("test fetch done");
		a1 = $urandom;
		e = '0;
		e.mm_fault = 1'b1;
		e.mm_addr = a1;
		pulse(e);
		rd("fsr", FSR, B7);
		rd("mmfar", MMFAR, a1);
		wr(FSR, B7);
		rd("fsr", FSR, 32'h0);
		$display("test mm valid done");
		repeat (3) @(posedge hclk);
		chk("reads left", 32'h0, exp_q.size());
		stop_test();
	end
endmodule // bus_fault_status_flags_tb
